// ### cdpr_consts.svh
// Purpose: offsets, field positions and reset values of the embedded RAM block
// Assumes: AXI4-Lite register window, 32-bit words, byte addresses below
// Notes: definitions only
//
// What this block does
// - storage of 4608 bits in total, parity bits included.
// - modes: true dual, simple dual, single port, FIFO, ROM, shift register.
// - RAM or ROM contents can be preloaded before operation starts.
// - each port offers 4096x1 down to 128x32 or 128x36 organizations.
// - no 128-deep 32 or 36-bit words in true dual-port mode.
// - simple dual-port mixes read and write widths within one group only.
// - true dual-port widths 1 to 16, or 9 and 18, never mixed.
// - shift register width times length times taps at most 4608 bits.
// - byte masking only for 16, 18, 32 or 36-bit write ports.
// - masked-off lanes keep their previously written value.
// - 9-bit lanes: mask bit k covers bits 9k+8 down to 9k.
// - any combination of mask bits is accepted on a write.
// - 8-bit lanes: mask bit k covers bits 8k+7 down to 8k.
// - output register may be clocked by either port's clock.
// - inputs always registered; only the output register can be bypassed.
// - clear empties input and output registers on the same edge.
// - shift mode reads the old word and writes the new one each shift.
// - each byte carries a parity bit usable for checking or control.
`ifndef CDPR_CONSTS_SVH
`define CDPR_CONSTS_SVH
`define CDPR_MEM_BITS 4608
`define CDPR_OFF_CTRL 8'h00
`define CDPR_OFF_WIDTH 8'h04
`define CDPR_OFF_STATUS 8'h08
`define CDPR_OFF_IADDR 8'h0C
`define CDPR_OFF_IDATA 8'h10
`define CDPR_CTRL_RUN 8
`define CDPR_CTRL_BYPA 9
`define CDPR_CTRL_BYPB 10
`define CDPR_CTRL_OSELA 11
`define CDPR_CTRL_OSELB 12
`define CDPR_CTRL_RST 32'h0000_0004
`define CDPR_WIDTH_RST 32'h0010_0100
`define CDPR_RESP_OK 2'h0
`define CDPR_RESP_ERR 2'h2
`endif

// ### cdpr_fabric_port.sv
// Purpose: fabric-side user logic driving one port of the RAM block
// Assumes: output register bypassed, port enable stands in for the port clock
// Notes: released lines other than en carry inverted values so stale data can never pass
`timescale 1ns/1ps
module cdpr_fabric_port (
   input wire logic core_clk,
   output logic en,
   output logic we,
   output logic clr,
   output logic [11:0] addr,
   output logic [35:0] wdata,
   output logic [3:0] mask,
   output logic resultValid
);
   initial begin
      en = 1'b0;
      we = 1'b0;
      clr = 1'b0;
      addr = 12'h000;
      wdata = 36'h0_0000_0000;
      mask = 4'h0;
      resultValid = 1'b0;
   end

   // ==========================================
   // port cycles
   task automatic access(input logic e, input logic w, input logic [11:0] a,
         input logic [35:0] d, input logic [3:0] m);
      @(posedge core_clk);
      en <= e;
      we <= w;
      addr <= a;
      wdata <= d;
      mask <= m;
      @(posedge core_clk);
      en <= 1'b0;
      // scrambled after capture: a design sampling late reads garbage
      we <= ~w;
      addr <= ~a;
      wdata <= ~d;
      mask <= ~m;
      @(posedge core_clk);
      resultValid <= e & ~w;
      @(posedge core_clk);
      resultValid <= 1'b0;
   endtask

   task automatic clear();
      @(posedge core_clk);
      clr <= 1'b1;
      @(posedge core_clk);
      clr <= 1'b0;
      resultValid <= 1'b1;
      @(posedge core_clk);
      resultValid <= 1'b0;
   endtask
endmodule

// ### cdpr_pkg.sv
// Purpose: types of the embedded RAM block
// Assumes: nothing
// Notes: width code 0..5 = 1,2,4,8,16,32 bits; 6..8 = 9,18,36 bits
package cdpr_pkg;
   typedef enum logic [5:0] {
      CDPR_TDP = 6'h01,
      CDPR_SDP = 6'h02,
      CDPR_SP = 6'h04,
      CDPR_FIFO = 6'h08,
      CDPR_ROM = 6'h10,
      CDPR_SHIFT = 6'h20
   } cdpr_mode_e;
   typedef logic [3:0] cdpr_wcode_t;
endpackage

// ### cdpr_top.sv
// Purpose: configurable dual-port RAM with AXI4-Lite configuration window
// Assumes: port controls come from fabric logic on core_clk
// Notes: port clocks are modelled as per-port enables on the one core clock
`timescale 1ns/1ps
`include "cdpr_consts.svh"
module cdpr_top
   import cdpr_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic portAEn,
   input wire logic portAWe,
   input wire logic portAClr,
   input wire logic [11:0] portAAddr,
   input wire logic [35:0] portAWdata,
   input wire logic [3:0] portAMask,
   output logic [35:0] portARdata,
   input wire logic portBEn,
   input wire logic portBWe,
   input wire logic portBClr,
   input wire logic [11:0] portBAddr,
   input wire logic [35:0] portBWdata,
   input wire logic [3:0] portBMask,
   output logic [35:0] portBRdata,
   output logic fifoEmpty,
   output logic fifoFull
);
   // ==========================================
   // width arithmetic
   function automatic logic [5:0] wBits(input cdpr_wcode_t c);
      case (c)
         4'h0: wBits = 6'h01;
         4'h1: wBits = 6'h02;
         4'h2: wBits = 6'h04;
         4'h3: wBits = 6'h08;
         4'h4: wBits = 6'h10;
         4'h5: wBits = 6'h20;
         4'h6: wBits = 6'h09;
         4'h7: wBits = 6'h12;
         4'h8: wBits = 6'h24;
         default: wBits = 6'h01;
      endcase
   endfunction

   function automatic logic isPar(input cdpr_wcode_t c);
      isPar = (c >= 4'h6) && (c <= 4'h8);
   endfunction

   function automatic logic [12:0] depthOf(input cdpr_wcode_t c);
      depthOf = isPar(c) ? 13'h0200 >> (c - 4'h6) : 13'h1000 >> c;
   endfunction

   function automatic logic maskOk(input cdpr_wcode_t c);
      maskOk = (c == 4'h4) || (c == 4'h5) || (c == 4'h7) || (c == 4'h8);
   endfunction

   // plain words skip every ninth bit, which holds the lane's parity
   function automatic logic [12:0] physIdx(input cdpr_wcode_t c, input logic [12:0] b);
      physIdx = isPar(c) ? b : b + {3'h0, b[12:3]};
   endfunction

   function automatic logic [12:0] bitBase(input cdpr_wcode_t c, input logic [11:0] a);
      logic [12:0] d;
      d = depthOf(c) - 13'h0001;
      bitBase = {1'b0, a & d[11:0]} * {7'h00, wBits(c)};
   endfunction

   function automatic logic [1:0] laneOf(input cdpr_wcode_t c, input int i);
      laneOf = 2'(isPar(c) ? i / 9 : i / 8);
   endfunction

   function automatic logic cfgOk(input logic [5:0] md, input logic [31:0] wr);
      logic [3:0] a;
      logic [3:0] b;
      logic [25:0] sz;
      a = wr[3:0];
      b = wr[7:4];
      sz = 26'(wBits(a)) * 26'(wr[19:8]) * 26'(wr[23:20]);
      case (md)
         CDPR_TDP: cfgOk = (a <= 4'h4 && b <= 4'h4) ||
                           (a >= 4'h6 && a <= 4'h7 && b >= 4'h6 && b <= 4'h7);
         CDPR_SDP: cfgOk = a <= 4'h8 && b <= 4'h8 && (isPar(a) == isPar(b));
         CDPR_SP, CDPR_FIFO, CDPR_ROM: cfgOk = a <= 4'h8;
         CDPR_SHIFT: cfgOk = a <= 4'h8 && sz != 26'h0 && sz <= `CDPR_MEM_BITS;
         default: cfgOk = 1'b0;
      endcase
   endfunction

   // ==========================================
   // configuration registers
   logic [31:0] ctrl;
   logic [31:0] widthCfg;
   logic cfgErr;
   logic [8:0] initAddr;
   logic awHeld, wHeld;
   logic [7:0] awAddrQ;
   logic [31:0] wDataQ;
   logic [3:0] wStrbQ;
   logic regWr, running, initWr;
   logic [31:0] next_ctrl, next_width;
   logic [5:0] mode;
   logic [4607:0] memBits;
   logic [12:0] fifoCnt, next_fifoCnt, shLen;
   logic [11:0] fifoWp, fifoRp, shPtr;

   function automatic logic [31:0] strbMerge(input logic [31:0] o, input logic [31:0] n,
                                             input logic [3:0] s);
      for (int k = 0; k < 4; k++) begin
         o[8*k +: 8] = s[k] ? n[8*k +: 8] : o[8*k +: 8];
      end
      strbMerge = o;
   endfunction

   assign mode = ctrl[5:0];
   assign running = ctrl[`CDPR_CTRL_RUN];
   assign regWr = awHeld && wHeld && !bvalid;
   assign next_ctrl = strbMerge(ctrl, wDataQ, wStrbQ);
   assign next_width = strbMerge(widthCfg, wDataQ, wStrbQ);
   // preload only while stopped, so fabric traffic never races the image
   assign initWr = regWr && awAddrQ == `CDPR_OFF_IDATA && !running;

   always_ff @(posedge core_clk) begin
      if (reset) begin
         awready <= 1'b1;
         wready <= 1'b1;
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         bvalid <= 1'b0;
         bresp <= `CDPR_RESP_OK;
         awAddrQ <= 8'h00;
         wDataQ <= 32'h0000_0000;
         wStrbQ <= 4'h0;
      end else begin
         if (awvalid && awready) begin
            awAddrQ <= awaddr;
            awHeld <= 1'b1;
            awready <= 1'b0;
         end
         if (wvalid && wready) begin
            wDataQ <= wdata;
            wStrbQ <= wstrb;
            wHeld <= 1'b1;
            wready <= 1'b0;
         end
         if (regWr) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            bvalid <= 1'b1;
            bresp <= (awAddrQ <= `CDPR_OFF_IDATA && awAddrQ[1:0] == 2'h0) ?
                     `CDPR_RESP_OK : `CDPR_RESP_ERR;
         end
         if (bvalid && bready) begin
            bvalid <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
         end
      end
   end

   // a run request with a bad combination is dropped and flagged
   always_ff @(posedge core_clk) begin
      if (reset) begin
         ctrl <= `CDPR_CTRL_RST;
         widthCfg <= `CDPR_WIDTH_RST;
         cfgErr <= 1'b0;
         initAddr <= 9'h000;
      end else if (regWr) begin
         if (awAddrQ == `CDPR_OFF_CTRL) begin
            ctrl <= next_ctrl;
            if (next_ctrl[`CDPR_CTRL_RUN] && !cfgOk(next_ctrl[5:0], widthCfg)) begin
               ctrl[`CDPR_CTRL_RUN] <= 1'b0;
            end
            cfgErr <= next_ctrl[`CDPR_CTRL_RUN] && !cfgOk(next_ctrl[5:0], widthCfg);
         end
         if (awAddrQ == `CDPR_OFF_WIDTH) begin
            widthCfg <= next_width;
            if (running && !cfgOk(mode, next_width)) begin
               ctrl[`CDPR_CTRL_RUN] <= 1'b0;
               cfgErr <= 1'b1;
            end
         end
         if (awAddrQ == `CDPR_OFF_IADDR) begin
            initAddr <= wDataQ[8:0];
         end
         if (initWr) begin
            initAddr <= initAddr + 9'h001;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= `CDPR_RESP_OK;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rresp <= `CDPR_RESP_OK;
         case (araddr)
            `CDPR_OFF_CTRL: rdata <= ctrl;
            `CDPR_OFF_WIDTH: rdata <= widthCfg;
            `CDPR_OFF_STATUS: rdata <= {19'h0_0000, fifoCnt};
            `CDPR_OFF_IADDR: rdata <= {23'h00_0000, initAddr};
            `CDPR_OFF_IDATA: rdata <= {23'h00_0000, memBits[9*initAddr +: 9]};
            default: begin
               rdata <= 32'h0000_0000;
               rresp <= `CDPR_RESP_ERR;
            end
         endcase
         if (araddr == `CDPR_OFF_STATUS) begin
            rdata[31] <= cfgErr;
         end
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
         arready <= 1'b1;
      end
   end

   // ==========================================
   // port input registers
   logic pEn[2], pWe[2], pClr[2];
   logic [11:0] pAddr[2];
   logic [35:0] pData[2];
   logic [3:0] pMask[2];
   logic inEn[2], inWe[2];
   logic [11:0] inAddr[2], effAddr[2];
   logic [35:0] inData[2], memQ[2], outQ[2], readVal[2];
   logic [3:0] inMask[2], effMask[2];
   cdpr_wcode_t wc[2];
   logic [12:0] addrBase[2];
   logic canWr[2], canRd[2], doWr[2], doRd[2];

   always_comb begin
      pEn[0] = portAEn;
      pWe[0] = portAWe;
      pClr[0] = portAClr;
      pAddr[0] = portAAddr;
      pData[0] = portAWdata;
      pMask[0] = portAMask;
      pEn[1] = portBEn;
      pWe[1] = portBWe;
      pClr[1] = portBClr;
      pAddr[1] = portBAddr;
      pData[1] = portBWdata;
      pMask[1] = portBMask;
   end

   always_ff @(posedge core_clk) begin
      for (int p = 0; p < 2; p++) begin
         if (reset || pClr[p]) begin
            inEn[p] <= 1'b0;
            inWe[p] <= 1'b0;
            inAddr[p] <= 12'h000;
            inData[p] <= 36'h0_0000_0000;
            inMask[p] <= 4'h0;
         end else begin
            inEn[p] <= pEn[p];
            if (pEn[p]) begin
               inWe[p] <= pWe[p];
               inAddr[p] <= pAddr[p];
               inData[p] <= pData[p];
               inMask[p] <= pMask[p];
            end
         end
      end
   end

   // ==========================================
   // mode decode and memory access
   assign shLen = 13'(widthCfg[19:8] * {8'h00, widthCfg[23:20]});

   always_comb begin
      wc[0] = widthCfg[3:0];
      wc[1] = (mode == CDPR_TDP || mode == CDPR_SDP || mode == CDPR_ROM) ?
              widthCfg[7:4] : widthCfg[3:0];
      canWr[0] = running && mode != CDPR_ROM;
      canWr[1] = running && mode == CDPR_TDP;
      canRd[0] = running && (mode == CDPR_TDP || mode == CDPR_SP || mode == CDPR_ROM);
      canRd[1] = running && mode != CDPR_SP;
      doWr[0] = canWr[0] && inEn[0] && inWe[0] && !(mode == CDPR_FIFO && fifoFull);
      doWr[1] = canWr[1] && inEn[1] && inWe[1];
      doRd[0] = canRd[0] && inEn[0] && !inWe[0];
      doRd[1] = mode == CDPR_SHIFT ? running && inEn[0] && inWe[0] :
                canRd[1] && inEn[1] && !inWe[1] && !(mode == CDPR_FIFO && fifoEmpty);
      effAddr[0] = mode == CDPR_FIFO ? fifoWp : mode == CDPR_SHIFT ? shPtr : inAddr[0];
      effAddr[1] = mode == CDPR_FIFO ? fifoRp : mode == CDPR_SHIFT ? shPtr : inAddr[1];
      for (int p = 0; p < 2; p++) begin
         effMask[p] = maskOk(wc[p]) ? inMask[p] : 4'hF;
         addrBase[p] = bitBase(wc[p], effAddr[p]);
         readVal[p] = 36'h0_0000_0000;
         for (int i = 0; i < 36; i++) begin
            if (i < wBits(wc[p])) begin
               readVal[p][i] = memBits[physIdx(wc[p], addrBase[p] + 13'(i))];
            end
         end
      end
   end

   // contents are not reset; on an A/B clash at one bit port B wins
   always_ff @(posedge core_clk) begin
      if (initWr) begin
         memBits[9*initAddr +: 9] <= wDataQ[8:0];
      end
      for (int p = 0; p < 2; p++) begin
         for (int i = 0; i < 36; i++) begin
            if (doWr[p] && i < wBits(wc[p]) && effMask[p][laneOf(wc[p], i)]) begin
               memBits[physIdx(wc[p], addrBase[p] + 13'(i))] <= inData[p][i];
            end
         end
      end
   end

   always_comb begin
      next_fifoCnt = fifoCnt;
      if (doWr[0] && mode == CDPR_FIFO) begin
         next_fifoCnt = next_fifoCnt + 13'h0001;
      end
      if (doRd[1] && mode == CDPR_FIFO) begin
         next_fifoCnt = next_fifoCnt - 13'h0001;
      end
   end

   // pointers restart whenever the block is stopped
   always_ff @(posedge core_clk) begin
      if (reset || !running) begin
         fifoCnt <= 13'h0000;
         fifoWp <= 12'h000;
         fifoRp <= 12'h000;
         shPtr <= 12'h000;
         fifoEmpty <= 1'b1;
         fifoFull <= 1'b0;
      end else begin
         fifoCnt <= next_fifoCnt;
         fifoEmpty <= next_fifoCnt == 13'h0000;
         fifoFull <= next_fifoCnt == depthOf(wc[0]);
         if (doWr[0] && mode == CDPR_FIFO) begin
            fifoWp <= (fifoWp + 12'h001) & 12'(depthOf(wc[0]) - 13'h0001);
         end
         if (doRd[1] && mode == CDPR_FIFO) begin
            fifoRp <= (fifoRp + 12'h001) & 12'(depthOf(wc[0]) - 13'h0001);
         end
         if (doWr[0] && mode == CDPR_SHIFT) begin
            shPtr <= ({1'b0, shPtr} + 13'h0001 >= shLen) ? 12'h000 : shPtr + 12'h001;
         end
      end
   end

   // ==========================================
   // output registers
   logic outEn[2], bypass[2];
   assign outEn[0] = ctrl[`CDPR_CTRL_OSELA] ? pEn[1] : pEn[0];
   assign outEn[1] = ctrl[`CDPR_CTRL_OSELB] ? pEn[0] : pEn[1];
   assign bypass[0] = ctrl[`CDPR_CTRL_BYPA];
   assign bypass[1] = ctrl[`CDPR_CTRL_BYPB];

   always_ff @(posedge core_clk) begin
      for (int p = 0; p < 2; p++) begin
         if (reset || pClr[p]) begin
            memQ[p] <= 36'h0_0000_0000;
            outQ[p] <= 36'h0_0000_0000;
         end else begin
            if (doRd[p]) begin
               memQ[p] <= readVal[p];
            end
            if (bypass[p] && doRd[p]) begin
               outQ[p] <= readVal[p];
            end else if (!bypass[p] && outEn[p]) begin
               outQ[p] <= memQ[p];
            end
         end
      end
   end
   assign portARdata = outQ[0];
   assign portBRdata = outQ[1];

   // ==========================================
   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   sequence rdReqA;
      doRd[0] && bypass[0] && !pClr[0];
   endsequence

   a_run_cfg_ok:
   assert property (running |-> cfgOk(mode, widthCfg))
      else $error("running with unsupported widths");
   a_tdp_no_wide:
   assert property (running && mode == CDPR_TDP |->
      wc[0] != 4'h5 && wc[0] != 4'h8 && wc[1] != 4'h5 && wc[1] != 4'h8)
      else $error("wide word in true dual-port");
   a_hold_idle:
   assert property (!portAEn && !portAClr |=> $stable(inAddr[0]) && !doWr[0])
      else $error("disabled port changed state");
   a_input_reg:
   assert property (portAEn && !portAClr |=> inAddr[0] == $past(portAAddr))
      else $error("address not registered");
   a_clear_out:
   assert property (portBClr |=> portBRdata == 36'h0_0000_0000 && !inEn[1] && !doWr[1])
      else $error("clear not applied");
   a_rom_no_write:
   assert property (running && mode == CDPR_ROM |-> !doWr[0] && !doWr[1])
      else $error("write in rom mode");
   a_narrow_mask:
   assert property (!maskOk(wc[0]) |-> effMask[0] == 4'hF)
      else $error("mask used on narrow port");
   a_bypass_lat:
   assert property (rdReqA ##1 !portAClr |-> portARdata == $past(readVal[0]))
      else $error("bypassed read late");
   a_shift_size:
   assert property (running && mode == CDPR_SHIFT |-> 26'(shLen) * 26'(wBits(wc[0])) <= 26'd4608)
      else $error("shift chain too long");
endmodule

// ### tb.sv
// Purpose: self-checking bench for the configurable dual-port RAM
// Assumes: both ports driven by cdpr_fabric_port models on core_clk
// Notes: expectations queue in order; the monitor pops one per result
`timescale 1ns/1ps
`include "cdpr_consts.svh"
`define CHK(g, e) \
   begin \
      checkCount++; \
      if ((g) !== (e)) begin \
         miscompares++; \
         $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); \
      end \
   end
module tb import cdpr_pkg::*;
;
   localparam logic [31:0] runBypass = (32'h1 << `CDPR_CTRL_RUN) |
      (32'h1 << `CDPR_CTRL_BYPA) | (32'h1 << `CDPR_CTRL_BYPB);
   logic core_clk, reset, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic aEn, aWe, aClr, bEn, bWe, bClr, aVal, bVal, fFull, fEmpty;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, lfsr;
   logic [3:0] wstrb, aMask, bMask;
   logic [1:0] bresp, rresp;
   logic [11:0] aAddr, bAddr;
   logic [35:0] aWdata, bWdata, portARdata, portBRdata;
   logic [35:0] expQ[$];
   int miscompares, checkCount, cycles;

   cdpr_top dut (.core_clk(core_clk), .reset(reset), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .portAEn(aEn), .portAWe(aWe), .portAClr(aClr), .portAAddr(aAddr),
      .portAWdata(aWdata), .portAMask(aMask), .portARdata(portARdata),
      .portBEn(bEn), .portBWe(bWe), .portBClr(bClr), .portBAddr(bAddr),
      .portBWdata(bWdata), .portBMask(bMask), .portBRdata(portBRdata),
      .fifoEmpty(fEmpty), .fifoFull(fFull));
   cdpr_fabric_port pA (.core_clk(core_clk), .en(aEn), .we(aWe), .clr(aClr), .addr(aAddr),
      .wdata(aWdata), .mask(aMask), .resultValid(aVal));
   cdpr_fabric_port pB (.core_clk(core_clk), .en(bEn), .we(bWe), .clr(bClr), .addr(bAddr),
      .wdata(bWdata), .mask(bMask), .resultValid(bVal));

   always #50 core_clk = ~core_clk;

   // ==========================================
   // helpers
   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h0040_0007 : 32'h0000_0000);
      return lfsr;
   endfunction

   function automatic logic [35:0] expMask(input logic [35:0] o, input logic [35:0] n,
         input logic [3:0] m, input int lw);
      logic [35:0] r;
      r = o;
      if (lw == 0) return n;
      for (int k = 0; k < 4; k++) begin
         for (int b = 0; b < lw; b++) begin
            if (m[k]) r[k * lw + b] = n[k * lw + b];
         end
      end
      return r;
   endfunction

   task automatic note(input logic [35:0] e);
      expQ.push_back(e);
   endtask

   task automatic take(input logic [35:0] got);
      logic [35:0] e;
      e = (expQ.size() != 0) ? expQ.pop_front() : 36'hx_xxxx_xxxx;
      `CHK(got, e)
   endtask

   task automatic giveVerdict();
      if (miscompares == 0 && checkCount > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // ==========================================
   // register bus master
   task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      bit aDone;
      bit wDone;
      aDone = 0;
      wDone = 0;
      note({34'h0, r});
      @(posedge core_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aDone && wDone)) begin
         @(posedge core_clk);
         if (!aDone && awready === 1'b1) begin
            awvalid <= 1'b0;
            aDone = 1;
         end
         if (!wDone && wready === 1'b1) begin
            wvalid <= 1'b0;
            wDone = 1;
         end
      end
      do @(posedge core_clk); while (bvalid !== 1'b1);
      bready <= 1'b0;
   endtask

   task automatic axiRead(input logic [7:0] a, input logic [31:0] d);
      note({2'h0, `CDPR_RESP_OK, d});
      @(posedge core_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge core_clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge core_clk); while (rvalid !== 1'b1);
      rready <= 1'b0;
   endtask

   task automatic setCfg(input cdpr_mode_e md, input logic [7:0] codes);
      axiWrite(`CDPR_OFF_CTRL, 32'(md), `CDPR_RESP_OK);
      axiWrite(`CDPR_OFF_WIDTH, (`CDPR_WIDTH_RST & 32'hFFFF_FF00) | 32'(codes), `CDPR_RESP_OK);
      axiWrite(`CDPR_OFF_CTRL, 32'(md) | runBypass, `CDPR_RESP_OK);
   endtask

   // ==========================================
   // monitor and watchdog
   always @(posedge core_clk) begin
      if (bvalid === 1'b1 && bready === 1'b1) take({34'h0, bresp});
      if (rvalid === 1'b1 && rready === 1'b1) take({2'h0, rresp, rdata});
      if (aVal === 1'b1) take(portARdata);
      if (bVal === 1'b1) take(portBRdata);
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         giveVerdict();
      end
   end

   // ==========================================
   // scenarios
   initial begin
      cdpr_mode_e bm[3] = '{CDPR_TDP, CDPR_TDP, CDPR_SDP};
      logic [7:0] bc[3] = '{8'h55, 8'h74, 8'h85};
      cdpr_mode_e tm[5] = '{CDPR_TDP, CDPR_TDP, CDPR_SDP, CDPR_SDP, CDPR_TDP};
      logic [3:0] tc[5] = '{4'h4, 4'h7, 4'h5, 4'h8, 4'h3};
      int tw[5] = '{16, 18, 32, 36, 8};
      int tl[5] = '{8, 9, 8, 9, 0};
      logic [8:0] ent[4];
      logic [35:0] old, nw, wm;
      logic [3:0] m;
      logic [11:0] ad;
      core_clk = 1'b0;
      reset = 1'b1;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0000_0000;
      wstrb = 4'hF;
      lfsr = 32'h2eef_4557;
      repeat (8) @(posedge core_clk);
      reset <= 1'b0;
      axiRead(`CDPR_OFF_CTRL, `CDPR_CTRL_RST);
      axiRead(`CDPR_OFF_WIDTH, `CDPR_WIDTH_RST);
      axiWrite(8'h20, 32'h0000_0000, `CDPR_RESP_ERR);
      for (int i = 0; i < 6; i++) begin
         axiWrite(`CDPR_OFF_CTRL, 32'h1 << i, `CDPR_RESP_OK);
         axiRead(`CDPR_OFF_CTRL, 32'h1 << i);
      end
      // preload while stopped, then read through both ports
      axiWrite(`CDPR_OFF_IADDR, 32'h0000_0000, `CDPR_RESP_OK);
      for (int i = 0; i < 4; i++) begin
         ent[i] = 9'(rnd());
         axiWrite(`CDPR_OFF_IDATA, {23'h0, ent[i]}, `CDPR_RESP_OK);
      end
      axiWrite(`CDPR_OFF_IADDR, 32'h0000_0002, `CDPR_RESP_OK);
      axiRead(`CDPR_OFF_IDATA, {23'h0, ent[2]});
      setCfg(CDPR_TDP, 8'h66);
      note({27'h0, ent[1]});
      pA.access(1'b1, 1'b0, 12'h001, 36'h0_0000_0000, 4'h0);
      note({27'h0, ent[3]});
      pB.access(1'b1, 1'b0, 12'h003, 36'h0_0000_0000, 4'h0);
      for (int i = 0; i < 3; i++) begin
         setCfg(bm[i], bc[i]);
         axiRead(`CDPR_OFF_STATUS, 32'h8000_0000);
         axiRead(`CDPR_OFF_CTRL, 32'(bm[i]) | (runBypass & 32'hFFFF_FEFF));
      end
      // top address of the 8, 16, 18, 32 and 36-bit organisations, masked writes
      for (int i = 0; i < 5; i++) begin
         setCfg(tm[i], {tc[i], tc[i]});
         axiRead(`CDPR_OFF_STATUS, 32'h0000_0000);
         ad = 12'(((tw[i] % 9 == 0) ? 4608 : 4096) / tw[i] - 1);
         wm = (36'h1 << tw[i]) - 36'h1;
         old = {4'(rnd()), rnd()} & wm;
         pA.access(1'b1, 1'b1, ad, old, 4'hF);
         for (int j = 0; j < 2; j++) begin
            nw = {4'(rnd()), rnd()};
            m = (j == 0) ? 4'(rnd()) : 4'h0;
            pA.access(1'b1, 1'b1, ad, nw, m);
            old = expMask(old, nw, m, tl[i]) & wm;
            note(old);
            pB.access(1'b1, 1'b0, ad, 36'h0_0000_0000, 4'h0);
         end
      end
      // write with the port disabled must leave memory alone
      pA.access(1'b0, 1'b1, ad, ~old, 4'hF);
      note(old);
      pB.access(1'b1, 1'b0, ad, 36'h0_0000_0000, 4'h0);
      // 16-bit writes read back as 8-bit words
      setCfg(CDPR_SDP, 8'h34);
      nw = {4'(rnd()), rnd()} & 36'h0_0000_FFFF;
      pA.access(1'b1, 1'b1, 12'h001, nw, 4'hF);
      note({28'h0, nw[7:0]});
      pB.access(1'b1, 1'b0, 12'h002, 36'h0_0000_0000, 4'h0);
      note({28'h0, nw[15:8]});
      pB.access(1'b1, 1'b0, 12'h003, 36'h0_0000_0000, 4'h0);
      // B output register unbypassed, advanced only by port A's enable
      axiWrite(`CDPR_OFF_CTRL, 32'(CDPR_SDP) | (32'h1 << `CDPR_CTRL_RUN) |
         (32'h1 << `CDPR_CTRL_OSELB), `CDPR_RESP_OK);
      note({28'h0, nw[15:8]});
      pB.access(1'b1, 1'b0, 12'h002, 36'h0_0000_0000, 4'h0);
      pA.access(1'b1, 1'b1, 12'h000, 36'h0_0000_0000, 4'hF);
      note({28'h0, nw[7:0]});
      pB.access(1'b1, 1'b0, 12'h002, 36'h0_0000_0000, 4'h0);
      // fifo push and pop, then a one-word shift chain, then rom
      setCfg(CDPR_FIFO, 8'h33);
      pA.access(1'b1, 1'b1, 12'h005, nw, 4'hF);
      `CHK({fFull, fEmpty}, 2'h0)
      note({28'h0, nw[7:0]});
      pB.access(1'b1, 1'b0, 12'h007, 36'h0_0000_0000, 4'h0);
      `CHK({fFull, fEmpty}, 2'h1)
      setCfg(CDPR_SHIFT, 8'h33);
      for (int j = 0; j < 2; j++) begin
         pA.access(1'b1, 1'b1, 12'h000, ~nw, 4'hF);
         note({28'h0, (j == 0) ? nw[7:0] : ~nw[7:0]});
         pB.access(1'b1, 1'b0, 12'h000, 36'h0_0000_0000, 4'h0);
      end
      setCfg(CDPR_ROM, 8'h33);
      pA.access(1'b1, 1'b1, 12'h000, nw, 4'hF);
      note({28'h0, ~nw[7:0]});
      pB.access(1'b1, 1'b0, 12'h000, 36'h0_0000_0000, 4'h0);
      note(36'h0_0000_0000);
      pB.clear();
      repeat (4) @(posedge core_clk);
      if (expQ.size() != 0) miscompares++;
      giveVerdict();
   end
endmodule
